//--- dv/pin_side_model.sv
// Far side of the timer: count and trigger pins with pull-ups, other timer overflow
module pin_side_model (
  input  wire logic clk,
  input  wire logic count_oe,
  input  wire logic count_out,
  output logic      count_pin_in,
  output logic      trigger_pin_in,
  output logic      other_timer_ovf
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       count_drive_n = 1'b1;
  logic [5:0] div           = 6'h00;
  // Pull-up gives high whenever nobody pulls low
  assign count_pin_in = count_oe ? count_out : count_drive_n;
  initial begin
    trigger_pin_in = 1'b1;
    other_timer_ovf = 1'b0;
  end
  always @(posedge clk) begin
    div <= (div == 6'h31) ? 6'h00 : div + 6'h01;
    other_timer_ovf <= (div == 6'h31);
  end
  // Levels held 30 clocks, over one machine cycle, so every level is sampled
  task automatic count_falls(input int n);
    repeat (n) begin
      @(posedge clk) count_drive_n <= 1'b0;
      repeat (30) @(posedge clk);
      count_drive_n <= 1'b1;
      repeat (30) @(posedge clk);
    end
  endtask : count_falls
  task automatic set_trigger(input logic v);
    @(posedge clk) trigger_pin_in <= v;
    repeat (30) @(posedge clk);
  endtask : set_trigger
endmodule : pin_side_model

//--- dv/timer2_control_and_modes_tb.sv
// Self-checking bench of the timer through its register bus and pins
`include "timer2_params.svh"
module timer2_control_and_modes_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk        = 1'b0;
  logic        srst       = 1'b1;
  logic [7:0]  addr       = 8'h00;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic [31:0] wdata      = 32'h0;
  logic [1:0]  smode      = 2'h0;
  logic        int_en     = 1'b0;
  logic [31:0] rdata;
  logic        wait_req;
  logic        pin_in, pin_out, pin_oe, trig, other_ovf, rx_clk, tx_clk, irq;
  logic [7:0]  q;
  logic [7:0]  q0;
  logic        lvl;
  logic [3:0]  be         = 4'h1;
  int          num_errors = 0;
  int          n_checks   = 0;
  int          cycles     = 0;
  int          rx_cnt     = 0;
  int          tx_cnt     = 0;
  int          r0, t0;

  timer2_control_and_modes DUT (
    .clk(clk), .srst(srst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .count_pin_in(pin_in), .count_pin_out(pin_out),
    .count_pin_oe(pin_oe), .trigger_pin_in(trig), .other_timer_ovf(other_ovf),
    .serial_mode(smode), .timer_int_en(int_en), .rx_bit_clock(rx_clk),
    .tx_bit_clock(tx_clk), .timer_irq(irq));
  pin_side_model pm (
    .clk(clk), .count_oe(pin_oe), .count_out(pin_out), .count_pin_in(pin_in),
    .trigger_pin_in(trig), .other_timer_ovf(other_ovf));

  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    rx_cnt <= rx_cnt + int'(rx_clk === 1'b1);
    tx_cnt <= tx_cnt + int'(tx_clk === 1'b1);
    // Tests need a few thousand cycles; this only cuts a hang
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= {24'h000000, d};
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    q = rdata[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr8
  task automatic rd8(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask : rd8
  task automatic set16(input logic [15:0] c, input logic [15:0] r);
    wr8(`COUNT_LO_OFFSET, c[7:0]);
    wr8(`COUNT_HI_OFFSET, c[15:8]);
    wr8(`CAPT_LO_OFFSET, r[7:0]);
    wr8(`CAPT_HI_OFFSET, r[15:8]);
  endtask : set16
  task automatic check_eq(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_eq
  task automatic check_in(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask : check_in

  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd8(`CTRL_OFFSET); check_eq(q, `CTRL_RESET);
    rd8(`MODE_OFFSET); check_eq(q, `MODE_RESET);
    wr8(8'he0, 8'hff);
    rd8(8'he0); check_eq(q, 8'h00);
    wr8(`CTRL_OFFSET, 8'h2b);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h2b);
    wr8(`CTRL_OFFSET, 8'h00);
    // Byte lane 0 off: the write must be dropped
    be <= 4'h0;
    wr8(`CTRL_OFFSET, 8'hff);
    be <= 4'h1;
    rd8(`CTRL_OFFSET); check_eq(q, 8'h00);
    $display("test register map done");
    set16(16'hfffe, 16'h1234);
    wr8(`CTRL_OFFSET, 8'h04);
    repeat (60) @(posedge clk);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h84);
    wr8(`CTRL_OFFSET, 8'h80);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h80);
    rd8(`COUNT_HI_OFFSET); check_eq(q, 8'h12);
    wr8(`CTRL_OFFSET, 8'h00);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h00);
    set16(16'h0000, 16'h0000);
    wr8(`CTRL_OFFSET, 8'h04);
    repeat (120) @(posedge clk);
    wr8(`CTRL_OFFSET, 8'h00);
    rd8(`COUNT_LO_OFFSET); check_in(q, 8'h09, 8'h0b);
    q0 = q;
    repeat (100) @(posedge clk);
    rd8(`COUNT_LO_OFFSET); check_eq(q, q0);
    set16(16'h0000, 16'h0000);
    wr8(`CTRL_OFFSET, 8'h06);
    pm.count_falls(5);
    wr8(`CTRL_OFFSET, 8'h00);
    rd8(`COUNT_LO_OFFSET); check_eq(q, 8'h05);
    $display("test counting done");
    set16(16'h0000, 16'haa55);
    wr8(`CTRL_OFFSET, 8'h05);
    pm.set_trigger(1'b0);
    pm.set_trigger(1'b1);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h05);
    rd8(`CAPT_HI_OFFSET); check_eq(q, 8'haa);
    wr8(`CTRL_OFFSET, 8'h0d);
    pm.set_trigger(1'b0);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h4d);
    rd8(`CAPT_HI_OFFSET); check_eq(q, 8'h00);
    rd8(`CAPT_LO_OFFSET); check_in(q, 8'h01, 8'h10);
    pm.set_trigger(1'b1);
    wr8(`CTRL_OFFSET, 8'h00);
    $display("test capture done");
    set16(16'hfff0, 16'hfff0);
    smode <= 2'h1;
    wr8(`CTRL_OFFSET, 8'h25);
    r0 = rx_cnt;
    t0 = tx_cnt;
    repeat (320) @(posedge clk);
    check_in(8'(rx_cnt - r0), 8'h09, 8'h0b);
    check_in(8'(tx_cnt - t0), 8'h05, 8'h07);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h25);
    wr8(`CTRL_OFFSET, 8'h15);
    r0 = rx_cnt;
    t0 = tx_cnt;
    repeat (320) @(posedge clk);
    check_in(8'(tx_cnt - t0), 8'h09, 8'h0b);
    check_in(8'(rx_cnt - r0), 8'h05, 8'h07);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h15);
    wr8(`CTRL_OFFSET, 8'h00);
    rd8(`COUNT_HI_OFFSET); check_eq(q, 8'hff);
    $display("test baud done");
    int_en <= 1'b1;
    wr8(`MODE_OFFSET, 8'h01);
    wr8(`CTRL_OFFSET, 8'h40);
    repeat (100) @(posedge clk);
    check_eq({7'h00, irq}, 8'h00);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h40);
    wr8(`MODE_OFFSET, 8'h00);
    repeat (3) @(posedge clk);
    check_eq({7'h00, irq}, 8'h01);
    wr8(`CTRL_OFFSET, 8'h00);
    repeat (3) @(posedge clk);
    check_eq({7'h00, irq}, 8'h00);
    $display("test interrupt done");
    set16(16'h0040, 16'h0000);
    wr8(`MODE_OFFSET, 8'h01);
    pm.set_trigger(1'b0);
    wr8(`CTRL_OFFSET, 8'h04);
    repeat (120) @(posedge clk);
    wr8(`CTRL_OFFSET, 8'h00);
    rd8(`COUNT_LO_OFFSET); check_in(q, 8'h34, 8'h37);
    pm.set_trigger(1'b1);
    set16(16'hfffc, 16'hfffc);
    wr8(`MODE_OFFSET, 8'h02);
    wr8(`CTRL_OFFSET, 8'h04);
    repeat (2) @(posedge clk);
    check_eq({7'h00, pin_oe}, 8'h01);
    // Four fast ticks per reload, so the pin flips every 8 clocks
    repeat (16) @(posedge clk);
    lvl = pin_out;
    repeat (8) @(posedge clk);
    check_eq({7'h00, pin_out}, {7'h00, ~lvl});
    wr8(`CTRL_OFFSET, 8'h06);
    repeat (2) @(posedge clk);
    check_eq({7'h00, pin_oe}, 8'h00);
    wr8(`CTRL_OFFSET, 8'h00);
    $display("test direction and clock out done");
    set16(16'h0000, 16'h5a00);
    wr8(`MODE_OFFSET, 8'h00);
    wr8(`CTRL_OFFSET, 8'h0c);
    pm.set_trigger(1'b0);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h4c);
    wr8(`CTRL_OFFSET, 8'h00);
    rd8(`COUNT_HI_OFFSET); check_eq(q, 8'h5a);
    pm.set_trigger(1'b1);
    set16(16'h0000, 16'h5a00);
    wr8(`CTRL_OFFSET, 8'h2c);
    pm.set_trigger(1'b0);
    rd8(`CTRL_OFFSET); check_eq(q, 8'h6c);
    wr8(`CTRL_OFFSET, 8'h00);
    rd8(`COUNT_HI_OFFSET); check_eq(q, 8'h00);
    pm.set_trigger(1'b1);
    $display("test trigger reload done");
    wrap_up();
  end
endmodule : timer2_control_and_modes_tb

//--- rtl/edge_sampler.sv
// Samples a pin once per strobe and flags a high-to-low change between samples
module edge_sampler (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic sample_strobe,
  input  wire logic pin,
  output logic      fall
);
  logic last_sample;

  always_ff @(posedge clk) begin
    if (srst) begin
      last_sample <= 1'b1;
      fall        <= 1'b0;
    end else begin
      fall <= sample_strobe & last_sample & ~pin;
      if (sample_strobe) begin
        last_sample <= pin;
      end
    end
  end
endmodule : edge_sampler

//--- rtl/timer2_control_and_modes.sv
// 16-bit timer/counter with control register, capture, reload and serial clock routing
`include "timer2_params.svh"

module timer2_control_and_modes
  import timer2_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              count_pin_in,
  output logic                   count_pin_out,
  output logic                   count_pin_oe,
  input  wire logic              trigger_pin_in,
  input  wire logic              other_timer_ovf,
  input  wire logic [1:0]        serial_mode,
  input  wire logic              timer_int_en,
  output logic                   rx_bit_clock,
  output logic                   tx_bit_clock,
  output logic                   timer_irq
);
  localparam logic [3:0] MC_LAST = 4'(`MACHINE_CYCLE_OSC - 1);

  logic [7:0]  counter_control_reg;
  logic [7:0]  mode_reg;
  logic [15:0] count;
  logic [15:0] capture;
  logic [3:0]  presc;
  logic        ack;
  logic        clk_out_level;
  logic [7:0]  next_ctrl;
  logic [15:0] next_count;
  logic [15:0] next_capture;
  logic        roll;
  mode_t       mode;

  wire overflow_flag       = counter_control_reg[`BIT_OVF_FLAG];
  wire external_edge_flag  = counter_control_reg[`BIT_EXT_FLAG];
  wire rx_clock_source_sel = counter_control_reg[`BIT_RX_SEL];
  wire tx_clock_source_sel = counter_control_reg[`BIT_TX_SEL];
  wire external_trigger_en = counter_control_reg[`BIT_TRIG_EN];
  wire run_control         = counter_control_reg[`BIT_RUN];
  wire count_source_sel    = counter_control_reg[`BIT_SRC_SEL];
  wire capture_reload_sel  = counter_control_reg[`BIT_CAP_SEL];
  wire down_count_en       = mode_reg[`BIT_DOWN_EN];
  wire clock_out_en        = mode_reg[`BIT_CLKOUT_EN];
  wire baud                = rx_clock_source_sel | tx_clock_source_sel;

  // Bus decode; one wait cycle on every access
  wire req        = avs_read | avs_write;
  wire wr_fire    = avs_write & ack & avs_byteenable[0];
  wire sel_ctrl   = avs_address == `CTRL_OFFSET;
  wire sel_cnt_lo = avs_address == `COUNT_LO_OFFSET;
  wire sel_cnt_hi = avs_address == `COUNT_HI_OFFSET;
  wire sel_cap_lo = avs_address == `CAPT_LO_OFFSET;
  wire sel_cap_hi = avs_address == `CAPT_HI_OFFSET;
  wire sel_mode   = avs_address == `MODE_OFFSET;
  wire wr_ctrl    = wr_fire & sel_ctrl;
  wire wr_count   = wr_fire & (sel_cnt_lo | sel_cnt_hi);
  wire wr_capture = wr_fire & (sel_cap_lo | sel_cap_hi);
  wire [7:0] wdata = avs_writedata[7:0];
  wire [7:0] rd_mux = sel_ctrl   ? counter_control_reg :
                      sel_cnt_lo ? count[7:0] :
                      sel_cnt_hi ? count[15:8] :
                      sel_cap_lo ? capture[7:0] :
                      sel_cap_hi ? capture[15:8] :
                      sel_mode   ? mode_reg : 8'h00;

  assign avs_waitrequest = req & ~ack;

  // Prescaler: machine cycle and state time strobes
  wire mc_tick    = presc == MC_LAST;
  wire state_tick = presc[0];

  logic count_fall;
  logic trig_fall;

  edge_sampler u_count_edge (
    .clk           (clk),
    .srst          (srst),
    .sample_strobe (mc_tick),
    .pin           (count_pin_in),
    .fall          (count_fall)
  );

  edge_sampler u_trig_edge (
    .clk           (clk),
    .srst          (srst),
    .sample_strobe (mc_tick),
    .pin           (trigger_pin_in),
    .fall          (trig_fall)
  );

  // Fast rate in baud and clock-out use, as the serial divider expects
  wire fast_rate  = baud | clock_out_en;
  wire int_tick   = fast_rate ? state_tick : mc_tick;
  wire count_step = count_source_sel ? count_fall : int_tick;
  wire trig_edge  = trig_fall & external_trigger_en;
  wire count_down = down_count_en & ~trigger_pin_in;

  assign mode = !run_control        ? MODE_OFF :
                baud                ? MODE_BAUD :
                capture_reload_sel  ? MODE_CAPTURE : MODE_RELOAD;

  always_comb begin
    next_count   = count;
    next_capture = capture;
    roll         = 1'b0;
    case (mode)
      MODE_RELOAD: begin
        if (count_step) begin
          if (count_down) begin
            if (count == capture) begin
              next_count = 16'hffff;
              roll       = 1'b1;
            end else begin
              next_count = count - 16'h0001;
            end
          end else if (count == 16'hffff) begin
            next_count = capture;
            roll       = 1'b1;
          end else begin
            next_count = count + 16'h0001;
          end
        end
        // Trigger pin is the direction input when down counting is on
        if (trig_edge && !down_count_en) begin
          next_count = capture;
        end
      end
      MODE_CAPTURE: begin
        if (count_step) begin
          next_count = count + 16'h0001;
          roll       = count == 16'hffff;
        end
        if (trig_edge) begin
          next_capture = count;
        end
      end
      MODE_BAUD: begin
        // Trigger edges only flag here, never reload
        if (count_step) begin
          if (count == 16'hffff) begin
            next_count = capture;
            roll       = 1'b1;
          end else begin
            next_count = count + 16'h0001;
          end
        end
      end
      default: begin
        next_count = count;
      end
    endcase
    // Software writes to the count win over a step in the same cycle
    if (wr_fire && sel_cnt_lo) begin
      next_count[7:0] = wdata;
    end
    if (wr_fire && sel_cnt_hi) begin
      next_count[15:8] = wdata;
    end
    // A hardware capture wins over a software write
    if (wr_fire && sel_cap_lo && !(mode == MODE_CAPTURE && trig_edge)) begin
      next_capture[7:0] = wdata;
    end
    if (wr_fire && sel_cap_hi && !(mode == MODE_CAPTURE && trig_edge)) begin
      next_capture[15:8] = wdata;
    end
  end

  wire ovf_set = roll & ~baud;
  wire ext_set = trig_edge & (mode != MODE_OFF);

  // Set wins over a software clear in the same cycle
  always_comb begin
    next_ctrl = wr_ctrl ? wdata : counter_control_reg;
    if (ovf_set) begin
      next_ctrl[`BIT_OVF_FLAG] = 1'b1;
    end
    if (ext_set) begin
      next_ctrl[`BIT_EXT_FLAG] = 1'b1;
    end
  end

  wire serial_mode_odd = serial_mode[0]; // Modes 1 and 3
  wire next_rx_clk = serial_mode_odd & (rx_clock_source_sel ? roll : other_timer_ovf);
  wire next_tx_clk = serial_mode_odd & (tx_clock_source_sel ? roll : other_timer_ovf);
  wire next_irq    = timer_int_en &
                     (overflow_flag | (external_edge_flag & ~down_count_en));

  always_ff @(posedge clk) begin
    if (srst) begin
      counter_control_reg <= `CTRL_RESET;
      mode_reg            <= `MODE_RESET;
      count               <= `COUNT_RESET;
      capture             <= `COUNT_RESET;
      presc               <= 4'h0;
      ack                 <= 1'b0;
      avs_readdata        <= 32'h0000_0000;
      clk_out_level       <= 1'b0;
      rx_bit_clock        <= 1'b0;
      tx_bit_clock        <= 1'b0;
      timer_irq           <= 1'b0;
    end else begin
      counter_control_reg <= next_ctrl;
      mode_reg            <= (wr_fire && sel_mode) ? {6'h00, wdata[1:0]} : mode_reg;
      count               <= next_count;
      capture             <= next_capture;
      presc               <= mc_tick ? 4'h0 : presc + 4'h1;
      ack                 <= req & ~ack;
      avs_readdata        <= (avs_read && !ack) ? {24'h000000, rd_mux} : avs_readdata;
      clk_out_level       <= (clock_out_en && roll) ? ~clk_out_level : clk_out_level;
      rx_bit_clock        <= next_rx_clk;
      tx_bit_clock        <= next_tx_clk;
      timer_irq           <= next_irq;
    end
  end

  // Clock out drives the pin only when enabled and the count source is internal; count input otherwise
  assign count_pin_out = clk_out_level;
  assign count_pin_oe  = clock_out_en & ~count_source_sel;

  sequence quiet_eight;
    !mc_tick [*8];
  endsequence

  sequence tick_after_quiet;
    quiet_eight ##1 !mc_tick ##1 !mc_tick ##1 !mc_tick ##1 mc_tick;
  endsequence

  chk_machine_tick: assert property (@(posedge clk) disable iff (srst)
    mc_tick |=> tick_after_quiet)
    else $error("machine cycle strobe not every twelve clocks");

  chk_ovf_flag_set: assert property (@(posedge clk) disable iff (srst)
    (roll && !baud) |=> overflow_flag ##1 (overflow_flag || $past(wr_ctrl)))
    else $error("overflow did not set overflow flag");

  chk_no_ovf_baud: assert property (@(posedge clk) disable iff (srst)
    $rose(overflow_flag) |-> $past(!baud || wr_ctrl))
    else $error("overflow flag set while serial clocking");

  chk_ext_flag_set: assert property (@(posedge clk) disable iff (srst)
    (trig_edge && run_control) |=> external_edge_flag)
    else $error("trigger edge did not set external edge flag");

  chk_ext_flag_hold: assert property (@(posedge clk) disable iff (srst)
    (external_edge_flag && !wr_ctrl) |=> external_edge_flag)
    else $error("external edge flag cleared by hardware");

  chk_irq_ext_flag: assert property (@(posedge clk) disable iff (srst)
    (timer_int_en && external_edge_flag && !down_count_en) |=> timer_irq)
    else $error("external edge flag did not request interrupt");

  chk_irq_down_mode: assert property (@(posedge clk) disable iff (srst)
    (down_count_en && !overflow_flag) |=> !timer_irq)
    else $error("interrupt raised from external edge in down mode");

  chk_rx_route: assert property (@(posedge clk) disable iff (srst)
    serial_mode_odd |=> rx_bit_clock ==
      $past(rx_clock_source_sel ? roll : other_timer_ovf))
    else $error("receive clock routed wrongly");

  chk_tx_route: assert property (@(posedge clk) disable iff (srst)
    serial_mode_odd |=> tx_bit_clock ==
      $past(tx_clock_source_sel ? roll : other_timer_ovf))
    else $error("transmit clock routed wrongly");

  chk_baud_no_reload: assert property (@(posedge clk) disable iff (srst)
    (mode == MODE_BAUD && trig_edge && !count_step && !wr_count) |=> $stable(count))
    else $error("trigger reloaded counter while serial clocking");

  chk_trig_ignored: assert property (@(posedge clk) disable iff (srst)
    (!external_trigger_en && trig_fall && !external_edge_flag && !wr_ctrl && !wr_capture)
      |=> (!external_edge_flag && $stable(capture)))
    else $error("trigger input not ignored");

  chk_hold_stopped: assert property (@(posedge clk) disable iff (srst)
    (!run_control && !wr_count) |=> $stable(count))
    else $error("counter moved while stopped");

  chk_capture_copy: assert property (@(posedge clk) disable iff (srst)
    (mode == MODE_CAPTURE && trig_edge) |=> capture == $past(count))
    else $error("capture did not copy count");

  chk_trig_reload: assert property (@(posedge clk) disable iff (srst)
    (mode == MODE_RELOAD && trig_edge && !down_count_en && !wr_count) |=> count == $past(capture))
    else $error("trigger edge did not reload counter");

  chk_baud_reload: assert property (@(posedge clk) disable iff (srst)
    (mode == MODE_BAUD && count_step && count == 16'hffff && !wr_count && !wr_capture)
      |=> count == $past(capture))
    else $error("baud rollover did not reload from capture pair");
endmodule : timer2_control_and_modes

//--- rtl/timer2_params.svh
// Register offsets, field positions, reset values and timing counts of the timer block
`ifndef TIMER2_PARAMS_SVH
`define TIMER2_PARAMS_SVH

`define CTRL_OFFSET       8'hc8
`define COUNT_LO_OFFSET   8'hcc
`define COUNT_HI_OFFSET   8'hd0
`define CAPT_LO_OFFSET    8'hd4
`define CAPT_HI_OFFSET    8'hd8
`define MODE_OFFSET       8'hdc

`define CTRL_RESET        8'h00
`define MODE_RESET        8'h00
`define COUNT_RESET       16'h0000

`define BIT_OVF_FLAG      7
`define BIT_EXT_FLAG      6
`define BIT_RX_SEL        5
`define BIT_TX_SEL        4
`define BIT_TRIG_EN       3
`define BIT_RUN           2
`define BIT_SRC_SEL       1
`define BIT_CAP_SEL       0
`define BIT_CLKOUT_EN     1
`define BIT_DOWN_EN       0

// Oscillator periods per machine cycle and per state time; one clk is one period
`define MACHINE_CYCLE_OSC 12
`define STATE_TIME_OSC    2

`endif

//--- rtl/timer2_pkg.sv
// Types shared by the timer block
package timer2_pkg;
  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_RELOAD  = 2'b01,
    MODE_CAPTURE = 2'b10,
    MODE_BAUD    = 2'b11
  } mode_t;
endpackage : timer2_pkg
